// *** verilog/psrs_pkg.sv ***
// constants and types for the serial register slave port
package psrs_pkg;

    // seven-bit device address on the bus
    localparam logic [6:0] PSRS_DEV_ADDR = 7'h34;
    // bit counter value of the acknowledge slot
    localparam logic [3:0] PSRS_BIT_ACK = 4'h8;
    // bit counter value after reset
    localparam logic [3:0] PSRS_BIT_RST = 4'h0;
    // byte shifter and register pointer after reset
    localparam logic [7:0] PSRS_BYTE_RST = 8'h00;
    // bus lines idle high, so synchronisers start high
    localparam logic PSRS_LINE_RST = 1'b1;

    // byte phase of the session, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01, // not addressed or no session
        ST_DEV = 5'h02,  // receiving device address byte
        ST_REG = 5'h04,  // receiving register address
        ST_DATA = 5'h08, // receiving data byte
        ST_TX = 5'h10    // sending register contents
    } psrs_state_t;

    // one register write handed to the register bank
    typedef struct packed {
        logic [7:0] addr; // target register
        logic [7:0] data; // value to store
    } psrs_wr_t;

endpackage : psrs_pkg

// *** verilog/psrs_slave.sv ***
// two-wire slave port that reads and writes control registers
`timescale 1ns/10ps
module psrs_slave
    import psrs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic incr_mode,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_ptr,
    output logic wr_stb,
    output psrs_wr_t wr,
    output logic bus_busy
);

    // link side: sampled bit and its toggle
    logic lk_bit;
    logic lk_tog;

    // system side synchronisers
    logic scl_s1;
    logic scl_s2;
    logic scl_p; // previous synced scl
    logic sda_s1;
    logic sda_s2;
    logic sda_p; // previous synced sda
    logic tog_s1;
    logic tog_s2;
    logic tog_p;

    // received bit event and its value
    logic rx_ev;
    logic rx_bit;

    // byte engine
    logic [3:0] bit_cnt; // 0..7 data bits, 8 ack slot
    logic [7:0] shreg;   // incoming byte, msb first
    logic [7:0] txsh;    // outgoing byte
    psrs_state_t state;
    psrs_state_t pend;   // phase taken at ack clock

    // decoded events
    logic start_ev;
    logic stop_ev;
    logic fall_ev;
    logic byte_end;
    logic ack_rise;
    logic addr_hit;

    // link clock: catch sda on every scl rising edge;
    // async clear because scl may stand still in reset
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            lk_bit <= 1'b0;
            lk_tog <= 1'b0;
        end else begin
            lk_bit <= sda_in; // stable while scl high
            lk_tog <= ~lk_tog;
        end
    end

    // two-flop synchronisers for pins and the toggle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_s1 <= PSRS_LINE_RST;
            scl_s2 <= PSRS_LINE_RST;
            scl_p <= PSRS_LINE_RST;
            sda_s1 <= PSRS_LINE_RST;
            sda_s2 <= PSRS_LINE_RST;
            sda_p <= PSRS_LINE_RST;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_p <= 1'b0;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_p <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_p <= sda_s2;
            tog_s1 <= lk_tog;
            tog_s2 <= tog_s1;
            tog_p <= tog_s2;
        end
    end

    // toggle change marks a new bit; the link bit has
    // been still for two system cycles, so it is safe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_ev <= 1'b0;
            rx_bit <= 1'b0;
        end else begin
            rx_ev <= tog_s2 ^ tog_p;
            if (tog_s2 ^ tog_p) begin
                rx_bit <= lk_bit;
            end
        end
    end

    // line conditions seen while scl stays high, then clock fall and byte decodes
    assign start_ev = scl_s2 & scl_p & sda_p & ~sda_s2;
    assign stop_ev = scl_s2 & scl_p & ~sda_p & sda_s2;
    assign fall_ev = scl_p & ~scl_s2;
    assign byte_end = fall_ev && (bit_cnt == PSRS_BIT_ACK);
    assign ack_rise = rx_ev && (bit_cnt == PSRS_BIT_ACK);
    assign addr_hit = (shreg[7:1] == PSRS_DEV_ADDR);

    // bus occupancy flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_busy <= 1'b0;
        end else if (start_ev) begin
            bus_busy <= 1'b1;
        end else if (stop_ev) begin
            bus_busy <= 1'b0;
        end
    end

    // bit counter and receive shifter; wraps every
    // nine clocks with no byte limit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bit_cnt <= PSRS_BIT_RST;
            shreg <= PSRS_BYTE_RST;
        end else if (start_ev || stop_ev) begin
            bit_cnt <= PSRS_BIT_RST;
        end else if (rx_ev) begin
            if (bit_cnt == PSRS_BIT_ACK) begin
                bit_cnt <= PSRS_BIT_RST;
            end else begin
                shreg <= {shreg[6:0], rx_bit};
                bit_cnt <= 4'(bit_cnt + 4'h1);
            end
        end
    end

    // byte phase; the next phase is decided when the
    // byte ends but taken at the ack clock, so the ack
    // slot itself still belongs to the finished byte
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            pend <= ST_IDLE;
            reg_ptr <= PSRS_BYTE_RST;
        end else if (start_ev) begin
            state <= ST_DEV;
            pend <= ST_IDLE;
        end else if (stop_ev) begin
            state <= ST_IDLE;
            pend <= ST_IDLE;
        end else if (byte_end) begin
            unique case (state)
                ST_DEV: begin
                    if (!addr_hit) begin
                        pend <= ST_IDLE;
                    end else if (shreg[0]) begin
                        pend <= ST_TX;
                    end else begin
                        pend <= ST_REG;
                    end
                end
                ST_REG: begin
                    reg_ptr <= shreg;
                    pend <= ST_DATA;
                end
                ST_DATA: begin
                    if (incr_mode) begin
                        // burst to consecutive registers
                        reg_ptr <= 8'(reg_ptr + 8'h01);
                        pend <= ST_DATA;
                    end else begin
                        pend <= ST_REG;
                    end
                end
                ST_TX: begin
                    pend <= ST_TX;
                end
                ST_IDLE: begin
                    pend <= ST_IDLE;
                end
                default: begin
                    pend <= ST_IDLE;
                end
            endcase
        end else if (ack_rise) begin
            if (state == ST_TX) begin
                if (rx_bit) begin
                    // master nack ends the read
                    state <= ST_IDLE;
                end else begin
                    reg_ptr <= 8'(reg_ptr + 8'h01);
                end
            end else begin
                state <= pend;
            end
        end
    end

    // data line drive, changed just after scl falls and released at a start or stop
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sda_oe <= 1'b0;
            txsh <= PSRS_BYTE_RST;
        end else if (start_ev || stop_ev) begin
            sda_oe <= 1'b0;
        end else if (fall_ev) begin
            if (bit_cnt == PSRS_BIT_ACK) begin
                // ack own address, register and data bytes; release when sending
                sda_oe <= (state == ST_DEV && addr_hit) ||
                          state == ST_REG ||
                          state == ST_DATA;
            end else if (state == ST_TX && bit_cnt == 4'h0) begin
                // register value read at the new pointer
                sda_oe <= ~reg_rdata[7];
                txsh <= {reg_rdata[6:0], 1'b0};
            end else if (state == ST_TX) begin
                sda_oe <= ~txsh[7];
                txsh <= {txsh[6:0], 1'b0};
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end

    // open-drain: the pin is only ever pulled low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // register write port towards the bank
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_stb <= 1'b0;
            wr <= '0;
        end else begin
            wr_stb <= byte_end && state == ST_DATA;
            if (byte_end && state == ST_DATA) begin
                wr.addr <= reg_ptr;
                wr.data <= shreg;
            end
        end
    end

    // checks on the system clock domain
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // end of a byte, before its ack slot
    sequence seq_byte_end;
        fall_ev && bit_cnt == PSRS_BIT_ACK;
    endsequence

    // a matching address byte
    sequence seq_addr_match;
        seq_byte_end ##0 (state == ST_DEV && addr_hit);
    endsequence

    AST_START_BUSY: assert property (
        start_ev |=> bus_busy && state == ST_DEV &&
            bit_cnt == PSRS_BIT_RST)
        else $error("start not taken");

    AST_STOP_FREE: assert property (
        stop_ev |=> !bus_busy && state == ST_IDLE && !sda_oe)
        else $error("stop not taken");

    AST_SHIFT_MSB: assert property (
        rx_ev && bit_cnt != PSRS_BIT_ACK && !start_ev &&
            !stop_ev |=> shreg[0] == $past(rx_bit) &&
            shreg[7:1] == $past(shreg[6:0]))
        else $error("bit not shifted msb first");

    // ack of the own address stands until the next clock fall,
    // six cycles at least with the fastest link clock
    AST_ADDR_ACK: assert property (
        seq_addr_match |=> sda_oe [*6])
        else $error("own address not acknowledged");

    AST_READ_DIR: assert property (
        seq_addr_match |=> pend == (shreg[0] ? ST_TX : ST_REG))
        else $error("direction bit misread");

    AST_IDLE_QUIET: assert property (
        state == ST_IDLE |-> !sda_oe)
        else $error("line driven while not addressed");

    AST_WRITE_STORE: assert property (
        seq_byte_end ##0 (state == ST_DATA) |=> wr_stb &&
            wr.data == $past(shreg) &&
            wr.addr == $past(reg_ptr))
        else $error("data byte not written");

    AST_INCR: assert property (
        seq_byte_end ##0 (state == ST_DATA && incr_mode) |=>
            reg_ptr == 8'($past(reg_ptr) + 8'h01))
        else $error("pointer did not advance");

    AST_RANDOM: assert property (
        seq_byte_end ##0 (state == ST_DATA && !incr_mode) |=>
            pend == ST_REG && reg_ptr == $past(reg_ptr))
        else $error("pair mode not kept");

    AST_TX_RELEASE: assert property (
        seq_byte_end ##0 (state == ST_TX) |=> !sda_oe)
        else $error("line held in master ack slot");

    // the pin moves only at a clock fall or a line condition
    AST_DRIVE_AT_FALL: assert property (
        !fall_ev && !start_ev && !stop_ev |=> $stable(sda_oe))
        else $error("data line moved outside a clock fall");

    // a repeated start goes back to the address byte
    AST_RESTART_ADDR: assert property (
        start_ev && bus_busy |=> state == ST_DEV && pend == ST_IDLE)
        else $error("repeated start not taken as a start");

    // the ninth clock wraps the counter, so bytes never run out
    AST_BIT_WRAP: assert property (
        ack_rise && !start_ev && !stop_ev |=>
            bit_cnt == PSRS_BIT_RST)
        else $error("bit counter did not wrap");

    // a foreign address is neither acknowledged nor followed
    AST_FOREIGN_NOACK: assert property (
        seq_byte_end ##0 (state == ST_DEV && !addr_hit) |=>
            !sda_oe && pend == ST_IDLE)
        else $error("foreign address answered");

    // master nack after a sent byte ends the read
    AST_NACK_END: assert property (
        ack_rise && state == ST_TX && rx_bit && !start_ev &&
            !stop_ev && !fall_ev |=> state == ST_IDLE)
        else $error("read not ended by nack");

    // each register write is a single-cycle strobe
    AST_WR_PULSE: assert property (
        wr_stb |=> !wr_stb)
        else $error("write strobe longer than one cycle");

endmodule : psrs_slave

// *** testbench/psrs_master_model.sv ***
// bus master model that drives the two-wire link from the far side
`timescale 1ns/10ps
module psrs_master_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // link idles with clock high and data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // start or repeated start: data falls while clock is high
    // waits 120 ns after a fall so the slave has let go of its ack
    task automatic start_cond();
        #120 sda_low = 1'b0;
        #40 scl = 1'b1;
        #160 sda_low = 1'b1;
        #160 scl = 1'b0;
    endtask : start_cond

    // stop: data rises while clock is high, clock then stays high
    task automatic stop_cond();
        #120 sda_low = 1'b1;
        #40 scl = 1'b1;
        #160 sda_low = 1'b0;
        #160;
    endtask : stop_cond

    // nine clocked bits, msb first, 160 ns per bit; a 1 in tx
    // releases the line; data moves only while the clock is low
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #40 sda_low = ~tx[i];
            #40 scl = 1'b1;
            #40 rx[i] = sda;
            #40 scl = 1'b0;
        end
    endtask : xfer
endmodule : psrs_master_model

// *** testbench/testbench.sv ***
// self-checking bench for the two-wire register slave port
`timescale 1ns/10ps
module testbench;
    import psrs_pkg::*;
    logic sys_clk = 1'b0; // 40 MHz system clock
    logic rst = 1'b1; // held high for six cycles
    logic incr_mode = 1'b0; // pair mode by default
    logic [7:0] reg_rdata = 8'h00; // register bank read path
    logic sda_out, sda_oe, wr_stb, bus_busy, scl, sda_low;
    logic [7:0] reg_ptr;
    psrs_wr_t wr;
    wire sda = (sda_low | sda_oe) ? 1'b0 : 1'b1; // open drain, pull-up
    logic [7:0] regs [256]; // register bank model
    int wr_cnt = 0; // write pulses seen
    int error_cnt = 0;
    int comparisons = 0;

    psrs_slave DUT (.sys_clk(sys_clk), .rst(rst), .scl_clk(scl),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .incr_mode(incr_mode), .reg_rdata(reg_rdata), .reg_ptr(reg_ptr),
        .wr_stb(wr_stb), .wr(wr), .bus_busy(bus_busy));
    psrs_master_model m (.scl(scl), .sda_low(sda_low), .sda(sda));

    // system clock, 25 ns period
    always #12.5 sys_clk = ~sys_clk;

    // register bank stores each write pulse
    always @(posedge sys_clk) begin
        if (wr_stb === 1'b1) begin
            regs[wr.addr] <= wr.data;
            wr_cnt++;
        end
    end

    // read data follows the pointer, moved off the sampling edge
    always @(negedge sys_clk) begin
        reg_rdata <= regs[reg_ptr];
    end

    // compare and count; unknowns never match
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // send one byte and check the slave's answer in the ninth slot
    task automatic send(input logic [7:0] b, input logic nack);
        logic [8:0] rx;
        m.xfer({b, 1'b1}, rx);
        chk({15'h0000, rx[0]}, {15'h0000, nack});
    endtask : send

    // clock one byte in from the slave, then ack or nack it
    task automatic fetch(input logic nack, input logic [7:0] exp);
        logic [8:0] rx;
        m.xfer({8'hFF, nack}, rx);
        chk({8'h00, rx[8:1]}, {8'h00, exp});
        chk({15'h0000, rx[0]}, {15'h0000, nack});
    endtask : fetch

    // random address and data pairs after one device address
    task automatic t_write_pairs();
        int n0;
        n0 = wr_cnt;
        m.start_cond();
        chk({15'h0000, bus_busy}, 16'h0001);
        send(8'h68, 1'b0);
        send(8'h10, 1'b0);
        send(8'hA5, 1'b0);
        send(8'h87, 1'b0);
        send(8'h3C, 1'b0);
        send(8'h11, 1'b0);
        send(8'h5A, 1'b0);
        m.stop_cond();
        chk({15'h0000, bus_busy}, 16'h0000);
        chk({8'h00, regs[8'h10]}, 16'h00A5);
        chk({8'h00, regs[8'h87]}, 16'h003C);
        chk({8'h00, regs[8'h11]}, 16'h005A);
        chk(16'(wr_cnt - n0), 16'h0003);
        $display("t_write_pairs done");
    endtask : t_write_pairs

    // increment mode: data bytes land in consecutive registers
    task automatic t_incr();
        @(negedge sys_clk) incr_mode <= 1'b1;
        m.start_cond();
        send(8'h68, 1'b0);
        send(8'h20, 1'b0);
        send(8'h11, 1'b0);
        send(8'h22, 1'b0);
        send(8'h33, 1'b0);
        m.stop_cond();
        @(negedge sys_clk) incr_mode <= 1'b0;
        chk({8'h00, regs[8'h20]}, 16'h0011);
        chk({8'h00, regs[8'h21]}, 16'h0022);
        chk({8'h00, regs[8'h22]}, 16'h0033);
        $display("t_incr done");
    endtask : t_incr

    // pointer write, repeated start, two bytes read, nack and stop
    task automatic t_read();
        m.start_cond();
        send(8'h68, 1'b0);
        send(8'h10, 1'b0);
        m.start_cond();
        chk({15'h0000, bus_busy}, 16'h0001);
        send(8'h69, 1'b0);
        fetch(1'b0, 8'hA5);
        fetch(1'b1, 8'h5A);
        chk({15'h0000, sda_oe}, 16'h0000);
        chk({15'h0000, sda_out}, 16'h0000);
        chk({8'h00, reg_ptr}, 16'h0011);
        m.stop_cond();
        chk({15'h0000, bus_busy}, 16'h0000);
        $display("t_read done");
    endtask : t_read

    // a foreign address is ignored until the next start
    task automatic t_foreign();
        int n0;
        n0 = wr_cnt;
        m.start_cond();
        send(8'h6A, 1'b1);
        send(8'h10, 1'b1);
        send(8'h00, 1'b1);
        m.stop_cond();
        chk(16'(wr_cnt - n0), 16'h0000);
        chk({8'h00, regs[8'h10]}, 16'h00A5);
        $display("t_foreign done");
    endtask : t_foreign

    // single place where the run ends
    task automatic print_verdict();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // main sequence: reset, settle, then the scenarios
    initial begin
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'h00;
        end
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk) rst <= 1'b0;
        // start on a falling edge so link edges never meet sampling
        repeat (4) @(negedge sys_clk);
        t_write_pairs();
        t_incr();
        t_read();
        t_foreign();
        print_verdict();
    end

    // watchdog at about three times the 33 us the scenarios need
    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end
endmodule : testbench
